// [csr_pkg.sv]
// Constants, field positions and operation codes for the core status and interrupt register bank
package csr_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int PTR_W  = 7;
	localparam int RAM_WORDS = 96;

	// Data locations
	localparam logic [6:0] ADR_PORT_ZERO  = 7'h00;
	localparam logic [6:0] ADR_PTR_ZERO   = 7'h01;
	localparam logic [6:0] ADR_PORT_ONE   = 7'h02;
	localparam logic [6:0] ADR_PTR_ONE    = 7'h03;
	localparam logic [6:0] ADR_BANK       = 7'h04;
	localparam logic [6:0] ADR_WORK       = 7'h05;
	localparam logic [6:0] ADR_FLAG       = 7'h0a;
	localparam logic [6:0] ADR_IRQ        = 7'h0b;
	localparam logic [6:0] ADR_SHARED_TOP = 7'h1f;
	localparam logic [6:0] ADR_RAM_BASE   = 7'h20;

	localparam logic [7:0] BANK_ONE = 8'h01;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	// Flag register fields
	localparam int FLG_CARRY = 0;
	localparam int FLG_HALF  = 1;
	localparam int FLG_ZERO  = 2;
	localparam int FLG_WRAP  = 3;
	localparam int FLG_PDOWN = 4;
	localparam int FLG_WDOG  = 5;
	localparam logic [7:0] FLAG_WR_MASK = 8'h0f;
	localparam logic [7:0] FLAG_RD_MASK = 8'h3f;
	localparam logic [7:0] FLAG_RESET   = 8'h00;

	// Interrupt control fields
	localparam int IRQ_GLOBAL   = 0;
	localparam int IRQ_EN_IFACE = 1;
	localparam int IRQ_EN_TIMER = 3;
	localparam int IRQ_PEND_IF  = 4;
	localparam int IRQ_PEND_TM  = 6;
	localparam logic [7:0] IRQ_MASK  = 8'h5b;
	localparam logic [7:0] IRQ_RESET = 8'h00;

	// Service locations
	localparam logic [7:0] VEC_IFACE = 8'h04;
	localparam logic [7:0] VEC_TIMER = 8'h0c;

	// Decimal adjust
	localparam logic [3:0] DEC_DIGIT_MAX = 4'h9;
	localparam logic [8:0] DAA_LO_FIX    = 9'h006;
	localparam logic [8:0] DAA_HI_FIX    = 9'h060;

	typedef enum logic [3:0] {
		ALU_ADD = 4'h0, ALU_ADC = 4'h1, ALU_SUB = 4'h2, ALU_SBC = 4'h3,
		ALU_DAA = 4'h4, ALU_AND = 4'h5, ALU_OR  = 4'h6, ALU_XOR = 4'h7,
		ALU_CPL = 4'h8, ALU_RL  = 4'h9, ALU_RR  = 4'ha, ALU_RLC = 4'hb,
		ALU_RRC = 4'hc, ALU_INC = 4'hd, ALU_DEC = 4'he, ALU_MOV = 4'hf
	} csr_alu_op_t;
endpackage

// [csr_alu.sv]
// Eight-bit arithmetic and logic unit with flag outputs and update enables
`timescale 1ns/100ps
`default_nettype none
module csr_alu
	import csr_pkg::*;
(
	input  wire csr_alu_op_t op,
	input  wire logic [7:0]  a,
	input  wire logic [7:0]  b,
	input  wire logic        c_in,
	input  wire logic        ac_in,
	output logic [7:0]       res,
	output logic             c_out,
	output logic             ac_out,
	output logic             ov_out,
	output logic             upd_c,
	output logic             upd_ac,
	output logic             upd_z,
	output logic             upd_ov
);
	logic [7:0] bb;
	logic       cin;
	logic [4:0] lo;
	logic [7:0] lo7;
	logic [8:0] full;
	logic [8:0] daa1;
	logic [8:0] daa2;

	always_comb begin
		// Subtraction is a plus inverted b plus one, or plus the carry flag for SBC, so carry means no borrow
		bb   = ((op == ALU_SUB) || (op == ALU_SBC)) ? ~b : b;
		cin  = (op == ALU_SUB) ? 1'b1 : (((op == ALU_ADC) || (op == ALU_SBC)) ? c_in : 1'b0);
		lo   = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
		lo7  = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, cin};
		full = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
		daa1 = {1'b0, a} + (((a[3:0] > DEC_DIGIT_MAX) || ac_in) ? DAA_LO_FIX : 9'h000);
		daa2 = daa1 + (((daa1[7:4] > DEC_DIGIT_MAX) || c_in || daa1[8]) ? DAA_HI_FIX : 9'h000);
		res = b;
		c_out = 1'b0;
		ac_out = 1'b0;
		ov_out = 1'b0;
		upd_c = 1'b0;
		upd_ac = 1'b0;
		upd_z = 1'b1;
		upd_ov = 1'b0;
		unique case (op)
			ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
				res = full[7:0];
				c_out = full[8];
				ac_out = lo[4];
				ov_out = lo7[7] ^ full[8];
				upd_c = 1'b1;
				upd_ac = 1'b1;
				upd_ov = 1'b1;
			end
			ALU_DAA: begin
				res = daa2[7:0];
				c_out = daa2[8] | daa1[8];
				upd_c = 1'b1;
				upd_z = 1'b0;
			end
			ALU_AND: res = a & b;
			ALU_OR:  res = a | b;
			ALU_XOR: res = a ^ b;
			ALU_CPL: res = ~b;
			ALU_RL: begin
				res = {b[6:0], b[7]};
				upd_z = 1'b0;
			end
			ALU_RR: begin
				res = {b[0], b[7:1]};
				upd_z = 1'b0;
			end
			ALU_RLC: begin
				res = {b[6:0], c_in};
				c_out = b[7];
				upd_c = 1'b1;
				upd_z = 1'b0;
			end
			ALU_RRC: begin
				res = {c_in, b[7:1]};
				c_out = b[0];
				upd_c = 1'b1;
				upd_z = 1'b0;
			end
			ALU_INC: res = b + 8'h01;
			ALU_DEC: res = b - 8'h01;
			ALU_MOV: upd_z = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// [csr_irq_arb.sv]
// Interrupt acknowledge decision with fixed priority and stack-full hold-off
`timescale 1ns/100ps
`default_nettype none
module csr_irq_arb
	import csr_pkg::*;
(
	input  wire logic [7:0] irqc,
	input  wire logic       stack_full,
	output logic            take_iface,
	output logic            take_timer
);
	logic go;
	logic want_if;
	logic want_tm;

	always_comb begin
		// A full stack holds every acknowledge; the pending flags stay untouched
		go = irqc[IRQ_GLOBAL] && !stack_full;
		want_if = irqc[IRQ_EN_IFACE] && irqc[IRQ_PEND_IF];
		want_tm = irqc[IRQ_EN_TIMER] && irqc[IRQ_PEND_TM];
		take_iface = go && want_if;
		take_timer = go && want_tm && !want_if;
	end
endmodule
`default_nettype wire

// [csr_core_regs.sv]
// Special register bank of the core: pointers, banks, work register, flags and interrupt control
`timescale 1ns/100ps
`default_nettype none
module csr_core_regs
	import csr_pkg::*;
#(
	parameter int RAM_DEPTH = csr_pkg::RAM_WORDS
)(
	input  wire logic                  clock,
	input  wire logic                  rstn,
	input  wire logic                  reg_en,
	input  wire logic                  reg_wr,
	input  wire logic [6:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	output logic [7:0]                 reg_rdata,
	output logic                       reg_rvalid,
	input  wire logic                  alu_go,
	input  wire csr_pkg::csr_alu_op_t  alu_op,
	input  wire logic [6:0]            alu_addr,
	input  wire logic                  alu_use_imm,
	input  wire logic [7:0]            alu_imm,
	input  wire logic                  alu_to_mem,
	input  wire logic                  alu_skip,
	output logic                       skip_taken,
	input  wire logic                  sleep_op,
	input  wire logic                  wdt_clear_op,
	input  wire logic                  wdt_timeout,
	input  wire logic                  return_from_irq,
	input  wire logic                  iface_req,
	input  wire logic                  timer_req,
	input  wire logic                  stack_full,
	output logic                       irq_call,
	output logic [7:0]                 irq_vector,
	output logic                       wake,
	output logic [7:0]                 work_register,
	output logic [7:0]                 flag_register,
	output logic [7:0]                 irq_control,
	output logic [7:0]                 bank_select
);
	import csr_pkg::*;

	// Both data banks sit in the state so that reset clears them, at some cost in area
	typedef struct packed {
		logic [PTR_W-1:0]                 mem_pointer_zero;
		logic [PTR_W-1:0]                 mem_pointer_one;
		logic [7:0]                       bank_select;
		logic [7:0]                       work_register;
		logic [7:0]                       flag_register;
		logic [7:0]                       irq_control;
		logic [RAM_DEPTH-1:0][7:0]        ram_zero;
		logic [RAM_DEPTH-1:0][7:0]        ram_one;
		logic [7:0]                       rdata;
		logic                             rvalid;
		logic                             call;
		logic [7:0]                       vector;
		logic                             skip;
		logic                             wake;
	} csr_state_t;

	typedef struct packed {
		logic       hole;
		logic       bank1;
		logic [6:0] addr;
	} csr_target_t;

	csr_state_t  st_ff;
	csr_state_t  nxt_st;
	logic        rst_n_meta_ff;
	logic        rst_n_sync_ff;
	csr_target_t alu_tgt;
	logic [7:0]  alu_b;
	logic [7:0]  alu_res;
	logic        alu_c;
	logic        alu_ac;
	logic        alu_ov;
	logic        alu_upd_c;
	logic        alu_upd_ac;
	logic        alu_upd_z;
	logic        alu_upd_ov;
	logic        take_iface;
	logic        take_timer;

	// Release of the asynchronous reset is retimed so all state leaves reset together
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rst_n_meta_ff <= 1'b0;
			rst_n_sync_ff <= 1'b0;
		end else begin
			rst_n_meta_ff <= 1'b1;
			rst_n_sync_ff <= rst_n_meta_ff;
		end
	end

	function automatic logic is_port(logic [6:0] a);
		return (a == ADR_PORT_ZERO) || (a == ADR_PORT_ONE);
	endfunction

	// Turns a data address into the location really touched
	function automatic csr_target_t resolve(logic [6:0] a, csr_state_t s);
		csr_target_t t;
		t.hole = 1'b0;
		t.bank1 = 1'b0;
		t.addr = a;
		if (a == ADR_PORT_ZERO) begin
			t.addr = s.mem_pointer_zero;
			t.bank1 = 1'b0;
			t.hole = is_port(s.mem_pointer_zero);
		end else if (a == ADR_PORT_ONE) begin
			t.addr = s.mem_pointer_one;
			// Only the exact value one selects bank one; any other value stays on bank zero
			t.bank1 = (s.bank_select == BANK_ONE);
			t.hole = is_port(s.mem_pointer_one);
		end
		return t;
	endfunction

	function automatic logic [6:0] ram_index(logic [6:0] a);
		return 7'(a - ADR_RAM_BASE);
	endfunction

	// Zero test shared by the zero flag and the skip decision
	function automatic logic is_zero(logic [7:0] v);
		return v == ZERO_BYTE;
	endfunction

	function automatic logic [7:0] read_loc(csr_target_t t, csr_state_t s);
		logic [7:0] d;
		d = ZERO_BYTE;
		if (t.hole) begin
			d = ZERO_BYTE;
		end else if (t.addr <= ADR_SHARED_TOP) begin
			// Low block ignores the bank so both banks see the same registers
			unique case (t.addr)
				ADR_PTR_ZERO: d = {1'b0, s.mem_pointer_zero};
				ADR_PTR_ONE:  d = {1'b0, s.mem_pointer_one};
				ADR_BANK:     d = s.bank_select;
				ADR_WORK:     d = s.work_register;
				ADR_FLAG:     d = s.flag_register & FLAG_RD_MASK;
				ADR_IRQ:      d = s.irq_control & IRQ_MASK;
				default:      d = ZERO_BYTE;
			endcase
		end else if (t.bank1) begin
			d = s.ram_one[ram_index(t.addr)];
		end else begin
			d = s.ram_zero[ram_index(t.addr)];
		end
		return d;
	endfunction

	function automatic csr_state_t write_loc(csr_state_t s, csr_target_t t, logic [7:0] d);
		csr_state_t r;
		r = s;
		if (t.hole) begin
			r = s;
		end else if (t.addr <= ADR_SHARED_TOP) begin
			unique case (t.addr)
				ADR_PTR_ZERO: r.mem_pointer_zero = d[PTR_W-1:0];
				ADR_PTR_ONE:  r.mem_pointer_one = d[PTR_W-1:0];
				ADR_BANK:     r.bank_select = d;
				ADR_WORK:     r.work_register = d;
				// Power-down and watchdog bits are owned by hardware events only
				ADR_FLAG:     r.flag_register = (s.flag_register & ~FLAG_WR_MASK)
				                             | (d & FLAG_WR_MASK);
				ADR_IRQ:      r.irq_control = d & IRQ_MASK;
				default:      r = s;
			endcase
		end else if (t.bank1) begin
			r.ram_one[ram_index(t.addr)] = d;
		end else begin
			r.ram_zero[ram_index(t.addr)] = d;
		end
		return r;
	endfunction

	// Acknowledge drops the global enable and the taken request and announces the vector
	function automatic csr_state_t acknowledge(csr_state_t s, int pend_bit, logic [7:0] vec);
		csr_state_t r;
		r = s;
		r.irq_control[IRQ_GLOBAL] = 1'b0;
		r.irq_control[pend_bit] = 1'b0;
		r.call = 1'b1;
		r.vector = vec;
		return r;
	endfunction

	// Operand fetch for the ALU; b is memory or immediate, a is always the work register
	always_comb begin
		alu_tgt = resolve(alu_addr, st_ff);
		alu_b = alu_use_imm ? alu_imm : read_loc(alu_tgt, st_ff);
	end

	csr_alu u_alu (
		.op     (alu_op),
		.a      (st_ff.work_register),
		.b      (alu_b),
		.c_in   (st_ff.flag_register[FLG_CARRY]),
		.ac_in  (st_ff.flag_register[FLG_HALF]),
		.res    (alu_res),
		.c_out  (alu_c),
		.ac_out (alu_ac),
		.ov_out (alu_ov),
		.upd_c  (alu_upd_c),
		.upd_ac (alu_upd_ac),
		.upd_z  (alu_upd_z),
		.upd_ov (alu_upd_ov)
	);

	csr_irq_arb u_arb (
		.irqc       (st_ff.irq_control),
		.stack_full (stack_full),
		.take_iface (take_iface),
		.take_timer (take_timer)
	);

	always_comb begin
		csr_target_t t;
		t = resolve(reg_addr, st_ff);
		nxt_st = st_ff;
		nxt_st.rvalid = 1'b0;
		nxt_st.call = 1'b0;
		nxt_st.skip = 1'b0;

		// ALU has the data path this cycle; a register access waits for the core to retry
		if (alu_go) begin
			if (alu_to_mem) begin
				nxt_st = write_loc(nxt_st, alu_tgt, alu_res);
			end else begin
				nxt_st.work_register = alu_res;
			end
			// Flag update follows the store, so the updated flag bits override an ALU result aimed at the flags
			if (alu_upd_c) begin
				nxt_st.flag_register[FLG_CARRY] = alu_c;
			end
			if (alu_upd_ac) begin
				nxt_st.flag_register[FLG_HALF] = alu_ac;
			end
			if (alu_upd_z) begin
				nxt_st.flag_register[FLG_ZERO] = is_zero(alu_res);
			end
			if (alu_upd_ov) begin
				nxt_st.flag_register[FLG_WRAP] = alu_ov;
			end
			nxt_st.skip = alu_skip && is_zero(alu_res);
		end else if (reg_en) begin
			if (reg_wr) begin
				nxt_st = write_loc(nxt_st, t, reg_wdata);
			end else begin
				nxt_st.rdata = read_loc(t, st_ff);
				nxt_st.rvalid = 1'b1;
			end
		end

		// Power-down and watchdog bits; a timeout wins over a clear in the same cycle
		if (sleep_op) begin
			nxt_st.flag_register[FLG_PDOWN] = 1'b1;
			nxt_st.flag_register[FLG_WDOG] = 1'b0;
		end
		if (wdt_clear_op) begin
			nxt_st.flag_register[FLG_PDOWN] = 1'b0;
			nxt_st.flag_register[FLG_WDOG] = 1'b0;
		end
		if (wdt_timeout) begin
			nxt_st.flag_register[FLG_WDOG] = 1'b1;
		end

		// An acknowledge in the same cycle overrides the re-enable of a return
		if (return_from_irq) begin
			nxt_st.irq_control[IRQ_GLOBAL] = 1'b1;
		end

		// Only the vector is announced; no flag state is saved on entry
		if (take_iface) begin
			nxt_st = acknowledge(nxt_st, IRQ_PEND_IF, VEC_IFACE);
		end else if (take_timer) begin
			nxt_st = acknowledge(nxt_st, IRQ_PEND_TM, VEC_TIMER);
		end

		// Hardware requests come last so they survive a same-cycle clear or ack
		if (iface_req) begin
			nxt_st.irq_control[IRQ_PEND_IF] = 1'b1;
		end
		if (timer_req) begin
			nxt_st.irq_control[IRQ_PEND_TM] = 1'b1;
		end

		// Wake ignores the enables so any source can end power-down
		nxt_st.wake = nxt_st.flag_register[FLG_PDOWN]
		              && (nxt_st.irq_control[IRQ_PEND_IF]
		              || nxt_st.irq_control[IRQ_PEND_TM]);
	end

	always_ff @(posedge clock or negedge rst_n_sync_ff) begin
		if (!rst_n_sync_ff) begin
			st_ff <= '0;
			st_ff.flag_register <= FLAG_RESET;
			st_ff.irq_control <= IRQ_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rdata     = st_ff.rdata;
	assign reg_rvalid    = st_ff.rvalid;
	assign skip_taken    = st_ff.skip;
	assign irq_call      = st_ff.call;
	assign irq_vector    = st_ff.vector;
	assign wake          = st_ff.wake;
	assign work_register = st_ff.work_register;
	assign flag_register = st_ff.flag_register;
	assign irq_control   = st_ff.irq_control;
	assign bank_select   = st_ff.bank_select;
endmodule
`default_nettype wire

// [csr_core_regs_sva.sv]
// Port checker for the core special register bank
`timescale 1ns/100ps
`default_nettype none
module csr_core_regs_chk
	import csr_pkg::*;
(
	input wire logic       clock,
	input wire logic       rstn,
	input wire logic       reg_en,
	input wire logic       reg_wr,
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rvalid,
	input wire logic       alu_go,
	input wire logic       sleep_op,
	input wire logic       wdt_clear_op,
	input wire logic       wdt_timeout,
	input wire logic       return_from_irq,
	input wire logic       iface_req,
	input wire logic       stack_full,
	input wire logic       irq_call,
	input wire logic [7:0] irq_vector,
	input wire logic       wake,
	input wire logic [7:0] work_register,
	input wire logic [7:0] flag_register,
	input wire logic [7:0] irq_control
);
	wire logic [1:0] pd_wd = flag_register[5:4];
	logic [1:0] run_ff;
	// Follows the design's two-stage reset release so checks start with its state
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			run_ff <= 2'b00;
		end else begin
			run_ff <= {run_ff[0], 1'b1};
		end
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!run_ff[1]);
	sequence iface_ready;
		irq_control[IRQ_GLOBAL] && irq_control[IRQ_EN_IFACE] && irq_control[IRQ_PEND_IF] && !stack_full;
	endsequence
	sequence timer_ready;
		irq_control[IRQ_GLOBAL] && irq_control[IRQ_EN_TIMER] && irq_control[IRQ_PEND_TM] && !stack_full;
	endsequence
	sequence call_to(logic [7:0] v);
		irq_call && irq_vector == v;
	endsequence
	read_work_a: assert property (
		reg_en && !reg_wr && !alu_go && reg_addr == ADR_WORK
		|=> reg_rvalid && reg_rdata == $past(work_register)) else $error("work read mismatch");
	unused_zero_a: assert property (
		flag_register[7:6] == 2'b00 && (irq_control & ~IRQ_MASK) == 8'h00) else $error("unused bit set");
	flag_guard_a: assert property (
		reg_en && reg_wr && !alu_go && reg_addr == ADR_FLAG && !sleep_op && !wdt_clear_op && !wdt_timeout
		|=> $stable(pd_wd)) else $error("power flags written by data");
	stack_hold_a: assert property (stack_full |=> !irq_call) else $error("ack with full stack");
	iface_first_a: assert property (
		iface_ready |=> call_to(VEC_IFACE)) else $error("interface ack missing");
	timer_next_a: assert property (
		timer_ready ##0 !(irq_control[IRQ_EN_IFACE] && irq_control[IRQ_PEND_IF])
		|=> call_to(VEC_TIMER)) else $error("timer ack missing");
	ack_clear_a: assert property (
		irq_call && !($past(reg_en) && $past(reg_wr)) && !$past(return_from_irq)
		|-> !irq_control[IRQ_GLOBAL]) else $error("global enable kept after ack");
	pend_latch_a: assert property (
		iface_req |=> irq_control[IRQ_PEND_IF]) else $error("request not latched");
	sleep_flags_a: assert property (
		sleep_op && !wdt_clear_op && !wdt_timeout |=> pd_wd == 2'b01) else $error("sleep flags wrong");
	wd_clear_a: assert property (
		wdt_clear_op && !wdt_timeout |=> pd_wd == 2'b00) else $error("watchdog clear flags wrong");
	timeout_a: assert property (
		wdt_timeout |=> flag_register[FLG_WDOG]) else $error("timeout flag not set");
	wake_up_a: assert property (
		flag_register[FLG_PDOWN] && (irq_control[IRQ_PEND_IF] || irq_control[IRQ_PEND_TM])
		|-> wake) else $error("no wake from power-down");
endmodule
`default_nettype wire

// [core_status_irq_regs_bench.sv]
// Self-checking bench for the core special register bank
`timescale 1ns/100ps
`default_nettype none
module core_status_irq_regs_bench;
	import csr_pkg::*;
	logic        clock = 1'b0;
	logic        rstn = 1'b0;
	logic        reg_en = 1'b0, reg_wr = 1'b0, alu_go = 1'b0, alu_use_imm = 1'b0;
	logic        alu_to_mem = 1'b0, alu_skip = 1'b0, sleep_op = 1'b0, wdt_clear_op = 1'b0;
	logic        wdt_timeout = 1'b0, return_from_irq = 1'b0, iface_req = 1'b0;
	logic        timer_req = 1'b0, stack_full = 1'b0;
	logic [6:0]  reg_addr = 7'h00, alu_addr = 7'h00;
	logic [7:0]  reg_wdata = 8'h00, alu_imm = 8'h00;
	csr_alu_op_t alu_op = ALU_ADD;
	logic [7:0]  reg_rdata, irq_vector, work_register, flag_register, irq_control, bank_select;
	logic        reg_rvalid, skip_taken, irq_call, wake;
	int          miscompares = 0;
	int          tests_run = 0;

	always #4 clock = ~clock;

	csr_core_regs #(.RAM_DEPTH(RAM_WORDS)) u_dut (.clock(clock), .rstn(rstn),
		.reg_en(reg_en), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .alu_go(alu_go), .alu_op(alu_op),
		.alu_addr(alu_addr), .alu_use_imm(alu_use_imm), .alu_imm(alu_imm),
		.alu_to_mem(alu_to_mem), .alu_skip(alu_skip), .skip_taken(skip_taken),
		.sleep_op(sleep_op), .wdt_clear_op(wdt_clear_op), .wdt_timeout(wdt_timeout),
		.return_from_irq(return_from_irq), .iface_req(iface_req), .timer_req(timer_req),
		.stack_full(stack_full), .irq_call(irq_call), .irq_vector(irq_vector), .wake(wake),
		.work_register(work_register), .flag_register(flag_register),
		.irq_control(irq_control), .bank_select(bank_select));

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk1(input string what, input logic exp, input logic got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_en <= 1'b1;
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_en <= 1'b0;
		#1;
	endtask

	// Read data is registered and stands from the taking edge for one cycle
	task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_en <= 1'b1;
		reg_wr <= 1'b0;
		reg_addr <= a;
		@(posedge clock);
		reg_en <= 1'b0;
		#1;
		chk1("read valid", 1'b1, reg_rvalid);
		chk8($sformatf("read %h", a), exp, reg_rdata);
	endtask

	task automatic alu(input csr_alu_op_t op, input logic [7:0] imm, input logic [6:0] a,
		input logic use_imm, input logic skip);
		@(posedge clock);
		alu_go <= 1'b1;
		alu_op <= op;
		alu_imm <= imm;
		alu_addr <= a;
		alu_use_imm <= use_imm;
		alu_skip <= skip;
		@(posedge clock);
		alu_go <= 1'b0;
		#1;
	endtask

	// Bits: return, timer request, interface request, timeout, watchdog clear, sleep
	task automatic pulse(input logic [5:0] m);
		@(posedge clock);
		{return_from_irq, timer_req, iface_req, wdt_timeout, wdt_clear_op, sleep_op} <= m;
		@(posedge clock);
		{return_from_irq, timer_req, iface_req, wdt_timeout, wdt_clear_op, sleep_op} <= 6'h00;
		#1;
	endtask

	task automatic wait_call(input logic [7:0] vec);
		int i;
		#1;
		for (i = 0; i < 6 && irq_call !== 1'b1; i++) begin
			@(posedge clock);
			#1;
		end
		if (irq_call !== 1'b1) begin
			miscompares++;
			$display("FAIL irq call expected 1 seen %b", irq_call);
			conclude();
		end
		chk8("irq vector", vec, irq_vector);
	endtask

	task automatic t_banks;
		rchk(ADR_FLAG, FLAG_RESET);
		rchk(7'h0c, ZERO_BYTE);
		wr(ADR_PTR_ZERO, 8'hb0);
		rchk(ADR_PTR_ZERO, 8'h30);
		wr(ADR_PORT_ZERO, 8'h5a);
		rchk(7'h30, 8'h5a);
		wr(ADR_BANK, BANK_ONE);
		chk8("bank select", BANK_ONE, bank_select);
		wr(ADR_PTR_ONE, 8'h30);
		wr(ADR_PORT_ONE, 8'ha5);
		rchk(7'h30, 8'h5a);
		rchk(ADR_PORT_ONE, 8'ha5);
		rchk(ADR_PORT_ZERO, 8'h5a);
		wr(ADR_WORK, 8'h3c);
		wr(ADR_PTR_ONE, 8'h05);
		rchk(ADR_PORT_ONE, 8'h3c);
		wr(ADR_PTR_ONE, 8'h02);
		wr(ADR_PORT_ONE, 8'h77);
		rchk(ADR_PORT_ONE, ZERO_BYTE);
		wr(ADR_PTR_ONE, 8'h30);
		wr(ADR_BANK, 8'h00);
		chk8("bank select", 8'h00, bank_select);
		rchk(ADR_PORT_ONE, 8'h5a);
		$display("bank test done");
	endtask

	task automatic t_alu;
		wr(ADR_WORK, 8'hff);
		alu(ALU_ADD, 8'h01, 7'h00, 1'b1, 1'b0);
		chk8("work", 8'h00, work_register);
		chk8("flags", 8'h07, flag_register);
		wr(ADR_WORK, 8'h7f);
		alu(ALU_ADD, 8'h01, 7'h00, 1'b1, 1'b0);
		chk8("flags", 8'h0a, flag_register);
		wr(ADR_WORK, 8'h05);
		alu(ALU_SUB, 8'h07, 7'h00, 1'b1, 1'b0);
		chk8("work", 8'hfe, work_register);
		chk8("flags", 8'h00, flag_register);
		alu(ALU_SUB, 8'h05, 7'h00, 1'b1, 1'b0);
		chk8("flags", 8'h03, flag_register);
		alu(ALU_RLC, 8'h40, 7'h00, 1'b1, 1'b0);
		chk8("work", 8'h81, work_register);
		chk8("flags", 8'h02, flag_register);
		alu(ALU_AND, 8'h00, 7'h00, 1'b1, 1'b1);
		chk1("skip", 1'b1, skip_taken);
		chk8("flags", 8'h06, flag_register);
		alu(ALU_MOV, 8'h00, 7'h30, 1'b0, 1'b0);
		rchk(ADR_WORK, 8'h5a);
		@(posedge clock);
		alu_to_mem <= 1'b1;
		alu(ALU_INC, 8'h00, 7'h30, 1'b0, 1'b0);
		@(posedge clock);
		alu_to_mem <= 1'b0;
		rchk(7'h30, 8'h5b);
		chk8("work", 8'h5a, work_register);
		wr(ADR_WORK, 8'h38);
		alu(ALU_ADD, 8'h45, 7'h00, 1'b1, 1'b0);
		alu(ALU_DAA, 8'h00, 7'h00, 1'b1, 1'b0);
		chk8("work", 8'h83, work_register);
		alu(ALU_ADD, 8'h17, 7'h00, 1'b1, 1'b0);
		alu(ALU_DAA, 8'h00, 7'h00, 1'b1, 1'b0);
		chk8("work", 8'h00, work_register);
		chk8("flags", 8'h01, flag_register);
		alu(ALU_ADC, 8'h0f, 7'h00, 1'b1, 1'b0);
		chk8("work", 8'h10, work_register);
		chk8("flags", 8'h02, flag_register);
		alu(ALU_SBC, 8'h0f, 7'h00, 1'b1, 1'b0);
		chk8("flags", 8'h05, flag_register);
		alu(ALU_DEC, 8'h00, 7'h00, 1'b1, 1'b0);
		chk8("work", 8'hff, work_register);
		alu(ALU_XOR, 8'h0f, 7'h00, 1'b1, 1'b0);
		chk8("work", 8'hf0, work_register);
		alu(ALU_OR, 8'h0f, 7'h00, 1'b1, 1'b0);
		chk8("work", 8'hff, work_register);
		alu(ALU_CPL, 8'h0f, 7'h00, 1'b1, 1'b0);
		chk8("work", 8'hf0, work_register);
		alu(ALU_RL, 8'h81, 7'h00, 1'b1, 1'b0);
		chk8("work", 8'h03, work_register);
		alu(ALU_RR, 8'h81, 7'h00, 1'b1, 1'b0);
		chk8("work", 8'hc0, work_register);
		alu(ALU_RRC, 8'h01, 7'h00, 1'b1, 1'b0);
		chk8("work", 8'h80, work_register);
		chk8("flags", 8'h01, flag_register);
		$display("alu test done");
	endtask

	task automatic t_flags;
		wr(ADR_FLAG, 8'hff);
		rchk(ADR_FLAG, 8'h0f);
		pulse(6'h01);
		chk8("flags", 8'h1f, flag_register);
		wr(ADR_FLAG, 8'h00);
		rchk(ADR_FLAG, 8'h10);
		pulse(6'h04);
		chk8("flags", 8'h30, flag_register);
		pulse(6'h01);
		chk8("flags", 8'h10, flag_register);
		pulse(6'h06);
		chk8("flags", 8'h20, flag_register);
		pulse(6'h02);
		chk8("flags", 8'h00, flag_register);
		$display("flag test done");
	endtask

	task automatic t_irq;
		rchk(ADR_IRQ, IRQ_RESET);
		wr(ADR_IRQ, 8'hfe);
		rchk(ADR_IRQ, 8'h5a);
		@(posedge clock);
		stack_full <= 1'b1;
		wr(ADR_IRQ, 8'h5b);
		repeat (4) begin
			@(posedge clock);
			#1;
			chk1("irq call", 1'b0, irq_call);
		end
		chk8("irq control", 8'h5b, irq_control);
		@(posedge clock);
		stack_full <= 1'b0;
		wait_call(VEC_IFACE);
		chk8("irq control", 8'h4a, irq_control);
		pulse(6'h08);
		chk8("irq control", 8'h5a, irq_control);
		pulse(6'h20);
		wait_call(VEC_IFACE);
		chk8("irq control", 8'h4a, irq_control);
		wr(ADR_IRQ, 8'h4b);
		wait_call(VEC_TIMER);
		chk8("irq control", 8'h0a, irq_control);
		pulse(6'h01);
		pulse(6'h10);
		@(posedge clock);
		#1;
		chk1("wake", 1'b1, wake);
		pulse(6'h02);
		chk1("wake", 1'b0, wake);
		wr(ADR_IRQ, 8'h0a);
		pulse(6'h01);
		chk1("wake", 1'b0, wake);
		pulse(6'h08);
		chk1("wake", 1'b1, wake);
		pulse(6'h02);
		$display("interrupt test done");
	endtask

	// Held a few edges so the two-flop release has settled before any request
	initial begin
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		repeat (3) @(posedge clock);
		t_banks();
		t_alu();
		t_flags();
		t_irq();
		conclude();
	end
endmodule

bind csr_core_regs csr_core_regs_chk u_chk (.clock(clock), .rstn(rstn), .reg_en(reg_en),
	.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.alu_go(alu_go), .sleep_op(sleep_op), .wdt_clear_op(wdt_clear_op),
	.wdt_timeout(wdt_timeout), .return_from_irq(return_from_irq), .iface_req(iface_req),
	.stack_full(stack_full), .irq_call(irq_call), .irq_vector(irq_vector), .wake(wake),
	.work_register(work_register), .flag_register(flag_register), .irq_control(irq_control));
`default_nettype wire
